/* File: src/sfod_pkg.sv */
// Package: opcode codes, protocol enums, framing descriptor and timing constants
package sfod_pkg;

  typedef enum logic [1:0] {
    SFOD_PROTO_SINGLE,
    SFOD_PROTO_DUAL,
    SFOD_PROTO_QUAD
  } sfod_proto_e;

  typedef struct packed {
    logic       valid;      // Opcode recognised in the active protocol
    logic [2:0] cmd_lanes;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
    logic [2:0] addr_bytes;
    logic [4:0] dummy;
    logic [8:0] data_min;
    logic [8:0] data_max;   // Zero means unlimited
    logic       dev_drives; // Data phase driven by the device
    logic       dtr;
  } sfod_frame_s;

  localparam logic [2:0] SFOD_L0 = 3'h0;
  localparam logic [2:0] SFOD_L1 = 3'h1;
  localparam logic [2:0] SFOD_L2 = 3'h2;
  localparam logic [2:0] SFOD_L4 = 3'h4;
  localparam logic [2:0] SFOD_ADDR3 = 3'h3;
  localparam logic [4:0] SFOD_DUMMY_6 = 5'h06;
  localparam logic [4:0] SFOD_DUMMY_8 = 5'h08;
  localparam logic [4:0] SFOD_DUMMY_10 = 5'h0a;
  localparam logic [8:0] SFOD_LEN_UNLIM = 9'h000;
  localparam logic [8:0] SFOD_LEN_1 = 9'h001;
  localparam logic [8:0] SFOD_LEN_2 = 9'h002;
  localparam logic [8:0] SFOD_LEN_20 = 9'h014;
  localparam logic [8:0] SFOD_LEN_256 = 9'h100;
  localparam logic [2:0] SFOD_BITS_PER_BYTE = 3'h7; // Last bit index

  localparam logic [7:0] SFOD_OP_RDID_MIO = 8'haf;
  localparam logic [7:0] SFOD_OP_RDSFDP = 8'h5a;
  localparam logic [7:0] SFOD_OP_FR_DO = 8'h3b;
  localparam logic [7:0] SFOD_OP_FR_DIO = 8'hbb;
  localparam logic [7:0] SFOD_OP_FR_QO = 8'h6b;
  localparam logic [7:0] SFOD_OP_FR_QIO = 8'heb;
  localparam logic [7:0] SFOD_OP_DTR_DO = 8'h3d;
  localparam logic [7:0] SFOD_OP_DTR_QO = 8'h6d;
  localparam logic [7:0] SFOD_OP_DTR_QIO = 8'hed;
  localparam logic [7:0] SFOD_OP_RD_FLAG = 8'h70;
  localparam logic [7:0] SFOD_OP_RD_VCFG = 8'h85;
  localparam logic [7:0] SFOD_OP_RD_EVCFG = 8'h65;
  localparam logic [7:0] SFOD_OP_RD_GPR = 8'h96;
  localparam logic [7:0] SFOD_OP_WR_NVCFG = 8'hb1;
  localparam logic [7:0] SFOD_OP_WR_EVCFG = 8'h61;
  localparam logic [7:0] SFOD_OP_CLR_FLAG = 8'h50;
  localparam logic [7:0] SFOD_OP_PP_DI = 8'ha2;
  localparam logic [7:0] SFOD_OP_PP_DIX = 8'hd2;
  localparam logic [7:0] SFOD_OP_PP_QI = 8'h32;
  localparam logic [7:0] SFOD_OP_PP_QIX = 8'h38;

endpackage : sfod_pkg

/* File: src/sfod_decoder.sv */
// Serial flash opcode decoder: samples the link, shifts the opcode, emits framing
// Notes on behaviour
// R1 - Multi-lane ID read: protocol lanes, 1-20 bytes
// R2 - Discovery read: 3 address bytes, 8 dummy
// R3 - Dual output read: 1-1-2/2-2-2, 8 dummy
// R4 - Dual I/O read: 1-2-2/2-2-2, 8 dummy
// R5 - Quad output read: 1-1-4 8, 4-4-4 10
// R6 - Quad I/O read: 1-4-4/4-4-4, 10 dummy
// R7 - DTR dual output read: 6 dummy, 3 address
// R8 - DTR quad output: 6 single, 8 quad
// R9 - DTR quad I/O read: 8 dummy in single and quad
// R10 - Flag read: no address, unlimited bytes
// R11 - Volatile config read: no address, no dummy
// R12 - Enhanced volatile config read: no address, no dummy
// R13 - General purpose read: 8 dummy, no address
// R14 - Nonvolatile config write: exactly two bytes
// R15 - Enhanced volatile config write: one byte
// R16 - Flag clear: command byte only
// R17 - Dual input program: 1-1-2, 1-256 bytes
// R18 - Extended dual program: 1-2-2 lanes
// R19 - Quad program: 1-1-4 or 4-4-4
// R20 - Extended quad program: 1-4-4, up to 256
// R21 - Command lanes follow the active protocol
// R22 - Fast read dummy counts come from nonzero configuration settings
// R23 - Select low frames; unknown opcode ignored
// R24 - Shift most significant bit first
`timescale 1ns/1ps
module sfod_decoder
  import sfod_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        link_clk_in,
  input  wire logic        sel_n_in,
  input  wire logic [3:0]  data_lane_in,
  input  wire sfod_proto_e proto_in,
  input  wire logic [4:0]  dummy_cfg_in,   // Configured dummy cycles, zero keeps default
  output logic             frame_valid_out,
  output logic [7:0]       opcode_out,
  output sfod_frame_s      frame_out,
  output logic             busy_out
);

  logic       rst_meta_reg;
  logic       rst_n_reg;
  logic [1:0] clk_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [3:0] lane_sync0_reg;
  logic [3:0] lane_sync1_reg;
  logic       clk_prev_reg;
  logic       sel_prev_n_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic       op_done_reg;
  logic       frame_valid_reg;
  logic [7:0] opcode_reg;
  sfod_frame_s frame_reg;
  logic       busy_reg;
  logic       rise;
  logic       in_frame;
  logic [2:0] cmd_w;
  logic [7:0] shift_next;
  logic [2:0] bits_next;
  sfod_frame_s decoded;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Two-stage synchronisers for link pins
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      clk_sync_reg   <= 2'h0;
      sel_sync_reg   <= 2'h3;
      lane_sync0_reg <= 4'h0;
      lane_sync1_reg <= 4'h0;
      clk_prev_reg   <= 1'b0;
      sel_prev_n_reg <= 1'b1;
    end else begin
      clk_sync_reg   <= {clk_sync_reg[0], link_clk_in};
      sel_sync_reg   <= {sel_sync_reg[0], sel_n_in};
      lane_sync0_reg <= data_lane_in;
      lane_sync1_reg <= lane_sync0_reg;
      clk_prev_reg   <= clk_sync_reg[1];
      sel_prev_n_reg <= sel_sync_reg[1];
    end
  end

  assign rise     = clk_sync_reg[1] && !clk_prev_reg;
  assign in_frame = !sel_sync_reg[1];

  function automatic logic [2:0] sfod_proto_lanes(input sfod_proto_e p);
    case (p)
      SFOD_PROTO_DUAL: sfod_proto_lanes = SFOD_L2;
      SFOD_PROTO_QUAD: sfod_proto_lanes = SFOD_L4;
      default:         sfod_proto_lanes = SFOD_L1;
    endcase
  endfunction : sfod_proto_lanes

  assign cmd_w = sfod_proto_lanes(proto_in); // [R21]

  // Opcode bits enter at the bottom, earliest bit ends at the top
  always_comb begin
    case (cmd_w)
      SFOD_L2: begin
        shift_next = {shift_reg[5:0], lane_sync1_reg[1:0]}; // [R24]
        bits_next  = bit_cnt_reg + 3'h2;
      end
      SFOD_L4: begin
        shift_next = {shift_reg[3:0], lane_sync1_reg}; // [R24]
        bits_next  = bit_cnt_reg + 3'h4;
      end
      default: begin
        shift_next = {shift_reg[6:0], lane_sync1_reg[0]}; // [R24]
        bits_next  = bit_cnt_reg + 3'h1;
      end
    endcase
  end

  function automatic sfod_frame_s sfod_mk(input logic [2:0] c, input logic [2:0] a,
      input logic [2:0] d, input logic [2:0] ab, input logic [4:0] dm,
      input logic [8:0] mn, input logic [8:0] mx, input logic dev, input logic dtr);
    sfod_frame_s f;
    f.valid = 1'b1;
    f.cmd_lanes = c;
    f.addr_lanes = a;
    f.data_lanes = d;
    f.addr_bytes = ab;
    f.dummy = dm;
    f.data_min = mn;
    f.data_max = mx;
    f.dev_drives = dev;
    f.dtr = dtr;
    sfod_mk = f;
  endfunction : sfod_mk

  // Framing table for each opcode in the active protocol
  function automatic sfod_frame_s sfod_decode(input logic [7:0] op, input sfod_proto_e p,
      input logic [4:0] cfg);
    sfod_frame_s f;
    logic [2:0] w;
    logic       q;
    logic       s;
    w = sfod_proto_lanes(p);
    q = (p == SFOD_PROTO_QUAD);
    s = (p == SFOD_PROTO_SINGLE);
    f = '0;
    case (op)
      SFOD_OP_RDID_MIO: f = sfod_mk(w, SFOD_L0, w, SFOD_L0, 5'h00, SFOD_LEN_1, SFOD_LEN_20,
          1'b1, 1'b0); // [R1]
      SFOD_OP_RDSFDP: f = sfod_mk(w, w, w, SFOD_ADDR3, SFOD_DUMMY_8, SFOD_LEN_1,
          SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R2]
      SFOD_OP_FR_DO: if (!q) f = sfod_mk(w, w, SFOD_L2, SFOD_ADDR3, SFOD_DUMMY_8,
          SFOD_LEN_1, SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R3]
      SFOD_OP_FR_DIO: if (!q) f = sfod_mk(w, SFOD_L2, SFOD_L2, SFOD_ADDR3, SFOD_DUMMY_8,
          SFOD_LEN_1, SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R4]
      SFOD_OP_FR_QO: if (s || q) f = sfod_mk(w, w, SFOD_L4, SFOD_ADDR3,
          q ? SFOD_DUMMY_10 : SFOD_DUMMY_8, SFOD_LEN_1, SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R5]
      SFOD_OP_FR_QIO: if (s || q) f = sfod_mk(w, SFOD_L4, SFOD_L4, SFOD_ADDR3, SFOD_DUMMY_10,
          SFOD_LEN_1, SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R6]
      SFOD_OP_DTR_DO: if (!q) f = sfod_mk(w, w, SFOD_L2, SFOD_ADDR3, SFOD_DUMMY_6,
          SFOD_LEN_1, SFOD_LEN_UNLIM, 1'b1, 1'b1); // [R7]
      SFOD_OP_DTR_QO: if (s || q) f = sfod_mk(w, w, SFOD_L4, SFOD_ADDR3,
          q ? SFOD_DUMMY_8 : SFOD_DUMMY_6, SFOD_LEN_1, SFOD_LEN_UNLIM, 1'b1, 1'b1); // [R8]
      SFOD_OP_DTR_QIO: if (s || q) f = sfod_mk(w, SFOD_L4, SFOD_L4, SFOD_ADDR3, SFOD_DUMMY_8,
          SFOD_LEN_1, SFOD_LEN_UNLIM, 1'b1, 1'b1); // [R9]
      SFOD_OP_RD_FLAG: f = sfod_mk(w, SFOD_L0, w, SFOD_L0, 5'h00, SFOD_LEN_1,
          SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R10]
      SFOD_OP_RD_VCFG: f = sfod_mk(w, SFOD_L0, w, SFOD_L0, 5'h00, SFOD_LEN_1,
          SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R11]
      SFOD_OP_RD_EVCFG: f = sfod_mk(w, SFOD_L0, w, SFOD_L0, 5'h00, SFOD_LEN_1,
          SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R12]
      SFOD_OP_RD_GPR: f = sfod_mk(w, SFOD_L0, w, SFOD_L0, SFOD_DUMMY_8, SFOD_LEN_1,
          SFOD_LEN_UNLIM, 1'b1, 1'b0); // [R13]
      SFOD_OP_WR_NVCFG: f = sfod_mk(w, SFOD_L0, w, SFOD_L0, 5'h00, SFOD_LEN_2, SFOD_LEN_2,
          1'b0, 1'b0); // [R14]
      SFOD_OP_WR_EVCFG: f = sfod_mk(w, SFOD_L0, w, SFOD_L0, 5'h00, SFOD_LEN_1, SFOD_LEN_1,
          1'b0, 1'b0); // [R15]
      SFOD_OP_CLR_FLAG: f = sfod_mk(w, SFOD_L0, SFOD_L0, SFOD_L0, 5'h00, 9'h000, 9'h000,
          1'b0, 1'b0); // [R16]
      SFOD_OP_PP_DI: if (!q) f = sfod_mk(w, w, SFOD_L2, SFOD_ADDR3, 5'h00, SFOD_LEN_1,
          SFOD_LEN_256, 1'b0, 1'b0); // [R17]
      SFOD_OP_PP_DIX: if (!q) f = sfod_mk(w, SFOD_L2, SFOD_L2, SFOD_ADDR3, 5'h00, SFOD_LEN_1,
          SFOD_LEN_256, 1'b0, 1'b0); // [R18]
      SFOD_OP_PP_QI: if (s || q) f = sfod_mk(w, w, SFOD_L4, SFOD_ADDR3, 5'h00, SFOD_LEN_1,
          SFOD_LEN_256, 1'b0, 1'b0); // [R19]
      SFOD_OP_PP_QIX: if (s || q) f = sfod_mk(w, SFOD_L4, SFOD_L4, SFOD_ADDR3, 5'h00,
          SFOD_LEN_1, SFOD_LEN_256, 1'b0, 1'b0); // [R20]
      default: f = '0;
    endcase
    // Configured count replaces the factory default on dummy-bearing fast reads
    if (f.valid && f.addr_bytes != SFOD_L0 && f.dummy != 5'h00 && cfg != 5'h00
        && op != SFOD_OP_RDSFDP) begin
      f.dummy = cfg; // [R22]
    end
    sfod_decode = f;
  endfunction : sfod_decode

  assign decoded = sfod_decode(shift_next, proto_in, dummy_cfg_in);

  // Opcode shifting within one select-low frame
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 3'h0;
      op_done_reg <= 1'b0;
    end else if (!in_frame) begin
      bit_cnt_reg <= 3'h0; // [R23]
      op_done_reg <= 1'b0;
    end else if (rise && !op_done_reg) begin
      shift_reg   <= shift_next;
      bit_cnt_reg <= bits_next;
      if ((bits_next == 3'h0) || (bit_cnt_reg == SFOD_BITS_PER_BYTE)) begin
        op_done_reg <= 1'b1;
      end
    end
  end

  // Decoded framing outputs, held until select rises
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      frame_valid_reg <= 1'b0;
      opcode_reg      <= 8'h00;
      frame_reg       <= '0;
      busy_reg        <= 1'b0;
    end else begin
      frame_valid_reg <= 1'b0;
      busy_reg        <= in_frame && (op_done_reg || rise || bit_cnt_reg != 3'h0);
      if (!in_frame) begin
        frame_reg <= '0; // [R23]
      end else if (rise && !op_done_reg &&
                   ((bits_next == 3'h0) || (bit_cnt_reg == SFOD_BITS_PER_BYTE))) begin
        opcode_reg      <= shift_next;
        frame_reg       <= decoded;
        frame_valid_reg <= decoded.valid; // [R23]
      end
    end
  end

  assign frame_valid_out = frame_valid_reg;
  assign opcode_out      = opcode_reg;
  assign frame_out       = frame_reg;
  assign busy_out        = busy_reg;

  AST_CLR_FLAG_BARE: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R16]
    frame_valid_reg && opcode_reg == SFOD_OP_CLR_FLAG |->
      frame_reg.addr_bytes == 3'h0 && frame_reg.data_max == 9'h000 && frame_reg.dummy == 5'h00)
    else $error("Flag clear framing not bare");

  AST_SFDP_DUMMY: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R2]
    frame_valid_reg && opcode_reg == SFOD_OP_RDSFDP |->
      frame_reg.dummy == SFOD_DUMMY_8 && frame_reg.addr_bytes == SFOD_ADDR3)
    else $error("Discovery read framing wrong");

  AST_DUAL_NOT_QUAD: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R3]
    frame_valid_reg |-> !(frame_reg.cmd_lanes == SFOD_L4 &&
      (opcode_reg == SFOD_OP_FR_DO || opcode_reg == SFOD_OP_FR_DIO)))
    else $error("Dual read accepted in quad protocol");

  AST_QUAD_NOT_DUAL: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R6]
    frame_valid_reg && frame_reg.cmd_lanes == SFOD_L2 |->
      opcode_reg != SFOD_OP_FR_QIO && opcode_reg != SFOD_OP_PP_QI)
    else $error("Quad opcode accepted in dual protocol");

  AST_NVCFG_LEN: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R14]
    frame_valid_reg && opcode_reg == SFOD_OP_WR_NVCFG |->
      frame_reg.data_min == SFOD_LEN_2 && frame_reg.data_max == SFOD_LEN_2)
    else $error("Nonvolatile write length wrong");

  AST_ID_LEN: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R1]
    frame_valid_reg && opcode_reg == SFOD_OP_RDID_MIO |->
      frame_reg.data_max == SFOD_LEN_20 && frame_reg.data_lanes == frame_reg.cmd_lanes)
    else $error("ID read framing wrong");

  AST_FRAME_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R23]
    sel_sync_reg[1] && !sel_prev_n_reg |=> !frame_reg.valid ##1 !frame_reg.valid)
    else $error("Framing survives select release");

  AST_VALID_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R23]
    frame_valid_reg |=> !frame_valid_reg)
    else $error("Frame valid not one cycle");

  AST_CMD_LANES: assert property (@(posedge clk_in) disable iff (!rst_n_reg) // [R21]
    frame_valid_reg |-> frame_reg.cmd_lanes != SFOD_L0)
    else $error("Command lane count zero");

endmodule : sfod_decoder

/* File: verif/sfod_host_model.sv */
// Host side model: drives link clock, select and lanes for one frame
`timescale 1ns/1ps
module sfod_host_model (
  output logic       link_clk_out,
  output logic       sel_n_out,
  output logic [3:0] data_lane_out
);
  initial begin
    link_clk_out = 1'b0;
    sel_n_out = 1'b1;
    data_lane_out = 4'h5;
  end

  // Clock stands still low outside frames; width is lanes per edge
  task automatic send(input logic [15:0] bits, input int nbits, input int width);
    int         i;
    logic [3:0] mask;
    mask = (width == 1) ? 4'h1 : (width == 2) ? 4'h3 : 4'hf;
    sel_n_out = 1'b0;
    for (i = 0; i < nbits; i += width) begin
      data_lane_out = (~data_lane_out & ~mask) | ((bits[15:12] >> (4 - width)) & mask);
      bits = bits << width;
      #400 link_clk_out = 1'b1;
      #400 link_clk_out = 1'b0;
    end
    #800 sel_n_out = 1'b1;
    data_lane_out = ~data_lane_out;
    #800;
  endtask : send
endmodule : sfod_host_model

/* File: verif/serial_flash_opcode_decoder_tb_top.sv */
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
`define SFOD_CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin \
  err_count++; $display("[FAIL] %0t %s", $time, m); end end
module serial_flash_opcode_decoder_tb_top;
  import sfod_pkg::*;
  logic        clk_in;
  logic        arst_n_in;
  wire  logic  link_clk;
  wire  logic  sel_n;
  wire  logic [3:0] lanes;
  sfod_proto_e proto_in;
  logic [4:0]  dummy_cfg_in;
  logic        frame_valid_out;
  logic [7:0]  opcode_out;
  sfod_frame_s frame_out;
  logic        busy_out;
  sfod_frame_s cap;
  logic        capb;
  int          pulses;
  int          err_count;
  int          cmp_count;
  int          seed;
  logic [7:0]  ops [22];

  sfod_host_model sfod_host_model_inst (.link_clk_out(link_clk), .sel_n_out(sel_n),
    .data_lane_out(lanes));
  sfod_decoder sfod_decoder_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .link_clk_in(link_clk), .sel_n_in(sel_n), .data_lane_in(lanes), .proto_in(proto_in),
    .dummy_cfg_in(dummy_cfg_in), .frame_valid_out(frame_valid_out), .opcode_out(opcode_out),
    .frame_out(frame_out), .busy_out(busy_out));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (frame_valid_out === 1'b1) begin
      pulses <= pulses + 1;
      cap <= frame_out;
      capb <= busy_out;
    end
  end

  function automatic sfod_frame_s exp_frame(input logic [7:0] op, input sfod_proto_e p,
                                            input logic [4:0] cfg);
    sfod_frame_s e;
    logic [2:0]  pl;
    logic        s;
    logic        d;
    logic        q;
    s = (p == SFOD_PROTO_SINGLE);
    d = (p == SFOD_PROTO_DUAL);
    q = (p == SFOD_PROTO_QUAD);
    pl = s ? SFOD_L1 : d ? SFOD_L2 : SFOD_L4;
    e = '0;
    e.valid = 1'b1;
    e.cmd_lanes = pl;
    e.data_lanes = pl;
    e.data_min = SFOD_LEN_1;
    e.dev_drives = 1'b1;
    if (op inside {8'h5a, 8'h3b, 8'hbb, 8'h6b, 8'heb, 8'h3d, 8'h6d, 8'hed, 8'ha2, 8'hd2,
                   8'h32, 8'h38}) e.addr_bytes = SFOD_ADDR3;
    case (op)
      8'haf: e.data_max = SFOD_LEN_20;
      8'h5a: begin e.addr_lanes = pl; e.dummy = SFOD_DUMMY_8; end
      8'h3b, 8'h3d, 8'hbb: begin
        e.valid = !q;
        e.addr_lanes = (s && op != 8'hbb) ? SFOD_L1 : SFOD_L2;
        e.data_lanes = SFOD_L2;
        e.dummy = (op == 8'h3d) ? SFOD_DUMMY_6 : SFOD_DUMMY_8;
        e.dtr = (op == 8'h3d);
      end
      8'h6b, 8'h6d: begin
        e.valid = !d;
        e.addr_lanes = s ? SFOD_L1 : SFOD_L4;
        e.data_lanes = SFOD_L4;
        if (op == 8'h6b) e.dummy = s ? SFOD_DUMMY_8 : SFOD_DUMMY_10;
        else e.dummy = s ? SFOD_DUMMY_6 : SFOD_DUMMY_8;
        e.dtr = (op == 8'h6d);
      end
      8'heb, 8'hed: begin
        e.valid = !d;
        e.addr_lanes = SFOD_L4;
        e.data_lanes = SFOD_L4;
        e.dummy = (op == 8'heb) ? SFOD_DUMMY_10 : SFOD_DUMMY_8;
        e.dtr = (op == 8'hed);
      end
      8'h70, 8'h85, 8'h65: ;
      8'h96: e.dummy = SFOD_DUMMY_8;
      8'hb1: begin
        e.dev_drives = 1'b0;
        e.data_min = SFOD_LEN_2;
        e.data_max = SFOD_LEN_2;
      end
      8'h61: begin e.dev_drives = 1'b0; e.data_max = SFOD_LEN_1; end
      8'h50: begin e.dev_drives = 1'b0; e.data_min = '0; e.data_lanes = SFOD_L0; end
      8'ha2, 8'hd2, 8'h32, 8'h38: begin
        e.valid = (op == 8'ha2 || op == 8'hd2) ? !q : !d;
        e.data_lanes = (op == 8'ha2 || op == 8'hd2) ? SFOD_L2 : SFOD_L4;
        e.addr_lanes = (s && (op == 8'ha2 || op == 8'h32)) ? SFOD_L1 : e.data_lanes;
        e.dev_drives = 1'b0;
        e.data_max = SFOD_LEN_256;
      end
      default: e.valid = 1'b0;
    endcase
    if (cfg != 5'h00 && op inside {8'h3b, 8'hbb, 8'h6b, 8'heb, 8'h3d, 8'h6d, 8'hed})
      e.dummy = cfg;
    if (!e.valid) e = '0;
    return e;
  endfunction : exp_frame

  task automatic run_op(input logic [7:0] op, input logic [7:0] op2, input int nbits,
                        input sfod_proto_e p, input logic [4:0] cfg);
    sfod_frame_s e;
    int          n0;
    int          w;
    e = exp_frame(op, p, cfg);
    w = (p == SFOD_PROTO_SINGLE) ? 1 : (p == SFOD_PROTO_DUAL) ? 2 : 4;
    @(posedge clk_in);
    proto_in <= p;
    dummy_cfg_in <= cfg;
    repeat (2) @(posedge clk_in);
    n0 = pulses;
    sfod_host_model_inst.send({op, op2}, nbits, w);
    `SFOD_CHK(pulses - n0, int'(e.valid), "pulse count")
    if (e.valid) begin
      `SFOD_CHK(cap, e, "frame fields")
      `SFOD_CHK(opcode_out, op, "opcode value")
      `SFOD_CHK(capb, 1'b1, "busy low during frame")
    end
    repeat (4) @(posedge clk_in);
    `SFOD_CHK(frame_out, sfod_frame_s'('0), "frame not cleared")
    `SFOD_CHK(busy_out, 1'b0, "busy after frame")
  endtask : run_op

  task automatic finish_test;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    repeat (90000) @(posedge clk_in);
    err_count++;
    finish_test();
  end

  initial begin
    int i;
    int p;
    ops = '{8'haf, 8'h5a, 8'h3b, 8'hbb, 8'h6b, 8'heb, 8'h3d, 8'h6d, 8'hed, 8'h70, 8'h85,
            8'h65, 8'h96, 8'hb1, 8'h61, 8'h50, 8'ha2, 8'hd2, 8'h32, 8'h38, 8'h00, 8'hff};
    arst_n_in = 1'b0;
    proto_in = SFOD_PROTO_SINGLE;
    dummy_cfg_in = 5'h00;
    pulses = 0;
    err_count = 0;
    cmp_count = 0;
    seed = 38;
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    for (p = 0; p < 3; p++)
      for (i = 0; i < 22; i++) run_op(ops[i], 8'h00, 8, sfod_proto_e'(p), 5'h00);
    for (i = 0; i < 30; i++)
      run_op(ops[$unsigned($random(seed)) % 22], 8'h00, 8,
             sfod_proto_e'($unsigned($random(seed)) % 3), 5'($random(seed)));
    run_op(8'h3b, 8'h70, 16, SFOD_PROTO_SINGLE, 5'h1f);
    run_op(8'h00, 8'h70, 16, SFOD_PROTO_QUAD, 5'h00);
    run_op(8'hed, 8'h5a, 16, SFOD_PROTO_QUAD, 5'h01);
    finish_test();
  end
endmodule : serial_flash_opcode_decoder_tb_top
